// ==== design/ifw_map.vh ====
/*
 * Register offsets, field positions, reset values and geometry counts for
 * the I2C queue and wake-up extension.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef IFW_MAP_VH
`define IFW_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IFW_OFS_CONTROL     8'h3c
`define IFW_OFS_STATUS      8'h40
`define IFW_OFS_EVENT       8'h44
`define IFW_OFS_EVENT_MASK  8'h48
`define IFW_OFS_TX_DATA     8'h4c
`define IFW_OFS_RX_DATA     8'h50

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define IFW_CTL_WAKE_EN     0
`define IFW_CTL_DUAL_EN     1
`define IFW_CTL_HOLD_DIS    2
`define IFW_CTL_OVER_IEN    3
`define IFW_CTL_STARVE_IEN  4
`define IFW_CTL_WIDTH       5

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define IFW_STA_WAKE        0
`define IFW_STA_TX_FULL     1
`define IFW_STA_RX_EMPTY    2
`define IFW_STA_OVER        3
`define IFW_STA_STARVE      4
`define IFW_STA_WIDTH       5

// ----------------------------------------------------------------------
// Event fields (read-to-clear) and reset values
// ----------------------------------------------------------------------
`define IFW_EVT_STARVE      0
`define IFW_EVT_OVER        1
`define IFW_EVT_WAKE        2
`define IFW_EVT_WIDTH       3
`define IFW_RST_CONTROL     5'h00
`define IFW_RST_STATUS      5'h00
`define IFW_RST_EVENT       3'h0

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define IFW_QUEUE_DEPTH     2
`define IFW_ADDR_SLOTS      4
`define IFW_BITS_PER_ADDR   8

`endif

// ==== design/ifw_queue.v ====
/*
 * Small byte queue with a run-time depth limit of one entry or the full
 * depth. Head entry sits in slot 0 and the queue shifts on a pop.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ifw_queue
#(
    parameter WIDTH = 8,
    parameter DEPTH = 2
)
(
    input  wire             clk,
    input  wire             srst,
    input  wire             deep,
    input  wire             push,
    input  wire             pop,
    input  wire [WIDTH-1:0] wdata,
    output wire [WIDTH-1:0] rdata,
    output wire             full,
    output wire             empty
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [7:0]       count_q;
    wire            do_pop;
    wire            do_push;
    wire [7:0]      limit;
    wire [7:0]      slot;
    integer         i;

    localparam [7:0] DEPTH_W = DEPTH;

    // Depth of one models plain single buffering
    assign limit   = deep ? DEPTH_W : 8'h01;
    assign empty   = (count_q == 8'h00);
    assign full    = (count_q >= limit);
    assign do_pop  = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign slot    = do_pop ? count_q - 8'h01 : count_q;
    assign rdata   = mem_q[0];

    // Shift on pop, write at the first free slot on push
    always @(posedge clk)
    begin
        if (srst)
        begin
            count_q <= 8'h00;
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= {WIDTH{1'b0}};
        end
        else
        begin
            for (i = 0; i < DEPTH; i = i + 1)
            begin
                if (do_push && (slot == i))
                    mem_q[i] <= wdata;
                else if (do_pop && (i < DEPTH - 1))
                    mem_q[i] <= mem_q[i+1];
            end
            count_q <= count_q + {7'h00, do_push} - {7'h00, do_pop};
        end
    end

endmodule

`default_nettype wire

// ==== design/ifw_top.v ====
/*
 * I2C extension: two-level transmit and receive queues with starve and
 * overflow detection, SCL hold control in master mode, and wake-up from
 * power-down on a matching bus address.
 * Assumes the base controller supplies its interrupt flag, mode, queue
 * strobes and slave addresses on clk; SCL and SDA arrive unsynchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.vh"

// Behaviour
// - Starve interrupt when enabled and queue on
// - Overflow interrupt when enabled and queue on
// - Hold SCL in master while flag pending
// - Queue enable selects two-entry or single buffering
// - Stop waits until queued final byte sent
// - Wake on address match during power-down
// - Wake flag set on wake, write-one clears
// - Starve status bit while queue enabled
// - Overflow status bit while queue enabled
// - Receive empty status while queue enabled
// - Transmit full status while queue enabled
// - Mask bits make address bits don't-care
module ifw_top
(
    input  wire        clk,
    input  wire        srst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    output reg         irq,
    input  wire        master_mode,
    input  wire        si_flag,
    input  wire        power_down,
    input  wire        core_tx_take,
    output reg  [7:0]  core_tx_data,
    input  wire        core_rx_push,
    input  wire [7:0]  core_rx_data,
    input  wire        start_request,
    input  wire        stop_request,
    output reg         start_issue,
    output reg         stop_issue,
    input  wire [27:0] own_slave_address,
    input  wire [27:0] slave_match_mask,
    output reg         wake_req,
    output reg         dual_queue_on,
    input  wire        scl_in,
    output reg         scl_out,
    output reg         scl_oe,
    input  wire        sda_in
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [`IFW_CTL_WIDTH-1:0] ctl_q;
    reg  [`IFW_STA_WIDTH-1:0] sticky_q;
    reg  [`IFW_EVT_WIDTH-1:0] evt_q;
    reg  [`IFW_EVT_WIDTH-1:0] evt_mask_q;
    reg  [2:0]                scl_sync_q;
    reg  [2:0]                sda_sync_q;
    reg  [7:0]                addr_shift_q;
    reg  [3:0]                bit_cnt_q;
    reg                       frame_q;
    reg                       stop_pend_q;
    reg  [31:0]               rdata_d;
    reg  [`IFW_EVT_WIDTH-1:0] evt_set;
    reg                       addr_match;
    integer                   k;
    wire                      wake_en;
    wire                      hold_dis;
    wire                      over_ien;
    wire                      starve_ien;
    wire                      wr_ctl;
    wire                      wr_sta;
    wire                      wr_tx;
    wire                      rd_rx;
    wire                      rd_evt;
    wire                      tx_full;
    wire                      tx_empty;
    wire                      rx_full;
    wire                      rx_empty;
    wire [7:0]                tx_head;
    wire [7:0]                rx_head;
    wire                      starve_evt;
    wire                      over_evt;
    wire                      wake_evt;
    wire                      scl_rise;
    wire                      start_seen;
    wire                      stop_seen;
    wire                      addr_done;

    // Masked address compare for one slot
    function hit;
        input [6:0] rx;
        input [6:0] own;
        input [6:0] mask;
        begin
            hit = &((~(rx ^ own)) | mask);
        end
    endfunction

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign wake_en    = ctl_q[`IFW_CTL_WAKE_EN];
    assign hold_dis   = ctl_q[`IFW_CTL_HOLD_DIS];
    assign over_ien   = ctl_q[`IFW_CTL_OVER_IEN];
    assign starve_ien = ctl_q[`IFW_CTL_STARVE_IEN];
    assign wr_ctl     = reg_wr && (reg_addr == `IFW_OFS_CONTROL);
    assign wr_sta     = reg_wr && (reg_addr == `IFW_OFS_STATUS);
    assign wr_tx      = reg_wr && (reg_addr == `IFW_OFS_TX_DATA);
    assign rd_rx      = reg_rd && (reg_addr == `IFW_OFS_RX_DATA);
    assign rd_evt     = reg_rd && (reg_addr == `IFW_OFS_EVENT);

    // ------------------------------------------------------------------
    // Transmit and receive queues
    // ------------------------------------------------------------------
    // queue depth select
    ifw_queue
    #(
        .WIDTH (8),
        .DEPTH (`IFW_QUEUE_DEPTH)
    )
    u_tx_queue
    (
        .clk   (clk),
        .srst  (srst),
        .deep  (ctl_q[`IFW_CTL_DUAL_EN]),
        .push  (wr_tx),
        .pop   (core_tx_take),
        .wdata (reg_wdata[7:0]),
        .rdata (tx_head),
        .full  (tx_full),
        .empty (tx_empty)
    );

    ifw_queue
    #(
        .WIDTH (8),
        .DEPTH (`IFW_QUEUE_DEPTH)
    )
    u_rx_queue
    (
        .clk   (clk),
        .srst  (srst),
        .deep  (ctl_q[`IFW_CTL_DUAL_EN]),
        .push  (core_rx_push),
        .pop   (rd_rx),
        .wdata (core_rx_data),
        .rdata (rx_head),
        .full  (rx_full),
        .empty (rx_empty)
    );

    // Errors only count while the two-level queue is switched in
    assign starve_evt = ctl_q[`IFW_CTL_DUAL_EN] && core_tx_take && tx_empty;
    assign over_evt   = ctl_q[`IFW_CTL_DUAL_EN] && core_rx_push && rx_full && !rd_rx;

    // ------------------------------------------------------------------
    // Bus line sampling and address capture
    // ------------------------------------------------------------------
    assign scl_rise   = scl_sync_q[1] && !scl_sync_q[2];
    assign start_seen = scl_sync_q[1] && sda_sync_q[2] && !sda_sync_q[1];
    assign stop_seen  = scl_sync_q[1] && !sda_sync_q[2] && sda_sync_q[1];
    assign addr_done  = frame_q && scl_rise && (bit_cnt_q == `IFW_BITS_PER_ADDR - 1);

    always @*
    begin
        addr_match = 1'b0;
        for (k = 0; k < `IFW_ADDR_SLOTS; k = k + 1)
            if (hit(addr_shift_q[6:0], // First seven bits; the eighth is R/W
                    own_slave_address[k*7 +: 7], slave_match_mask[k*7 +: 7]))
                addr_match = 1'b1;
    end

    // wake only in power-down with enable set
    assign wake_evt = addr_done && addr_match && wake_en && power_down;

    // Two-stage synchronisers plus a history stage for edges
    always @(posedge clk)
    begin
        if (srst)
        begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
        end
    end

    // Address shifter armed by a start condition
    always @(posedge clk)
    begin
        if (srst)
        begin
            addr_shift_q <= 8'h00;
            bit_cnt_q    <= 4'h0;
            frame_q      <= 1'b0;
        end
        else if (start_seen)
        begin
            bit_cnt_q <= 4'h0;
            frame_q   <= 1'b1;
        end
        else if (stop_seen || addr_done)
        begin
            frame_q <= 1'b0;
        end
        else if (frame_q && scl_rise)
        begin
            addr_shift_q <= {addr_shift_q[6:0], sda_sync_q[1]};
            bit_cnt_q    <= bit_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Control, sticky status and event registers
    // ------------------------------------------------------------------
    always @*
    begin
        evt_set = {`IFW_EVT_WIDTH{1'b0}};
        evt_set[`IFW_EVT_STARVE] = starve_evt;
        evt_set[`IFW_EVT_OVER]   = over_evt;
        evt_set[`IFW_EVT_WAKE]   = wake_evt;
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            ctl_q      <= `IFW_RST_CONTROL;
            sticky_q   <= `IFW_RST_STATUS;
            evt_q      <= `IFW_RST_EVENT;
            evt_mask_q <= `IFW_RST_EVENT;
        end
        else
        begin
            if (wr_ctl)
                ctl_q <= reg_wdata[`IFW_CTL_WIDTH-1:0];
            if (reg_wr && (reg_addr == `IFW_OFS_EVENT_MASK))
                evt_mask_q <= reg_wdata[`IFW_EVT_WIDTH-1:0];
            if (starve_evt)
                sticky_q[`IFW_STA_STARVE] <= 1'b1;
            else if (wr_sta && reg_wdata[`IFW_STA_STARVE])
                sticky_q[`IFW_STA_STARVE] <= 1'b0;
            if (over_evt)
                sticky_q[`IFW_STA_OVER] <= 1'b1;
            else if (wr_sta && reg_wdata[`IFW_STA_OVER])
                sticky_q[`IFW_STA_OVER] <= 1'b0;
            if (wake_evt)
                sticky_q[`IFW_STA_WAKE] <= 1'b1;
            else if (wr_sta && reg_wdata[`IFW_STA_WAKE])
                sticky_q[`IFW_STA_WAKE] <= 1'b0;
            // Event bits clear on read unless set again
            evt_q <= (rd_evt ? {`IFW_EVT_WIDTH{1'b0}} : evt_q) | evt_set;
        end
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `IFW_OFS_CONTROL:
                rdata_d[`IFW_CTL_WIDTH-1:0] = ctl_q;
            `IFW_OFS_STATUS:
            begin
                rdata_d[`IFW_STA_STARVE] = sticky_q[`IFW_STA_STARVE];
                rdata_d[`IFW_STA_OVER]   = sticky_q[`IFW_STA_OVER];
                rdata_d[`IFW_STA_WAKE]   = sticky_q[`IFW_STA_WAKE];
                rdata_d[`IFW_STA_RX_EMPTY] = ctl_q[`IFW_CTL_DUAL_EN] && rx_empty;
                rdata_d[`IFW_STA_TX_FULL]  = ctl_q[`IFW_CTL_DUAL_EN] && tx_full;
            end
            `IFW_OFS_EVENT:
                rdata_d[`IFW_EVT_WIDTH-1:0] = evt_q;
            `IFW_OFS_EVENT_MASK:
                rdata_d[`IFW_EVT_WIDTH-1:0] = evt_mask_q;
            `IFW_OFS_RX_DATA:
                rdata_d[7:0] = rx_head;
            default:
                rdata_d = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst)
        begin
            reg_rdata     <= 32'h0000_0000;
            irq           <= 1'b0;
            core_tx_data  <= 8'h00;
            wake_req      <= 1'b0;
            dual_queue_on <= 1'b0;
            scl_out       <= 1'b0;
            scl_oe        <= 1'b0;
        end
        else
        begin
            reg_rdata     <= reg_rd ? rdata_d : 32'h0000_0000;
            irq <= (starve_ien && ctl_q[`IFW_CTL_DUAL_EN] && sticky_q[`IFW_STA_STARVE])
                || (over_ien && ctl_q[`IFW_CTL_DUAL_EN] && sticky_q[`IFW_STA_OVER])
                || (|(evt_q & evt_mask_q));
            core_tx_data  <= tx_head;
            wake_req      <= wake_evt;
            dual_queue_on <= ctl_q[`IFW_CTL_DUAL_EN];
            scl_out       <= 1'b0;
            // hold SCL low while flag pending
            scl_oe        <= master_mode && si_flag && !hold_dis;
        end
    end

    // ------------------------------------------------------------------
    // Start and stop forwarding
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst)
        begin
            start_issue <= 1'b0;
            stop_issue  <= 1'b0;
            stop_pend_q <= 1'b0;
        end
        else
        begin
            // start passed on only if flag clear or queue off, else dropped
            start_issue <= start_request && !(ctl_q[`IFW_CTL_DUAL_EN] && si_flag);
            // stop held until the last queued byte is taken
            if (stop_issue)
                stop_pend_q <= 1'b0;
            else if (stop_request)
                stop_pend_q <= 1'b1;
            stop_issue <= !stop_issue && (stop_pend_q || stop_request)
                && (!ctl_q[`IFW_CTL_DUAL_EN] || (tx_empty && !si_flag));
        end
    end

endmodule

`default_nettype wire

// ==== tb/ifw_asserts.sv ====
/*
 * Port checks for the I2C queue and wake-up extension.
 * Assumes it is bound into ifw_top and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.vh"
module ifw_asserts
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        master_mode,
    input wire logic        si_flag,
    input wire logic        power_down,
    input wire logic        start_request,
    input wire logic        start_issue,
    input wire logic        stop_issue,
    input wire logic        wake_req,
    input wire logic        dual_queue_on,
    input wire logic        scl_out,
    input wire logic        scl_oe
);
    // -----------------------------------------------------------------
    // Checks on one clock
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Control register write seen on the port
    wire ctl_wr = reg_wr && reg_addr == `IFW_OFS_CONTROL;
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    a_scl_hold: assert property (scl_oe |-> $past(master_mode && si_flag) && !scl_out)
        else $error("scl held without pending flag in master");
    a_hold_free: assert property ($fell(si_flag) |=> !scl_oe)
        else $error("scl still held after flag cleared");
    a_queue_sel: assert property ($past(ctl_wr, 2) |-> dual_queue_on == $past(reg_wdata[1], 2))
        else $error("queue enable not taken from write");
    a_queue_hold: assert property (!$past(ctl_wr, 2) |-> $stable(dual_queue_on))
        else $error("queue enable changed without write");
    a_start_gate: assert property (start_request && !(dual_queue_on && si_flag) |=> start_issue)
        else $error("start not passed on");
    a_start_cause: assert property (start_issue |-> $past(start_request && !(dual_queue_on && si_flag)))
        else $error("start issued without allowed request");
    a_stop_gate: assert property (stop_issue |-> $past(!dual_queue_on || !si_flag))
        else $error("stop issued while flag pending");
    a_stop_pulse: assert property (stop_issue |=> !stop_issue)
        else $error("stop issue longer than one cycle");
    a_wake_cond: assert property (wake_req |-> $past(power_down))
        else $error("wake outside power-down");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
endmodule
bind ifw_top ifw_asserts ifw_asserts_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_mode(master_mode), .si_flag(si_flag), .power_down(power_down),
    .start_request(start_request), .start_issue(start_issue), .stop_issue(stop_issue),
    .wake_req(wake_req), .dual_queue_on(dual_queue_on), .scl_out(scl_out), .scl_oe(scl_oe));
`default_nettype wire

// ==== tb/ifw_bus_master.sv ====
/*
 * Behavioural I2C master that sends one address byte per call.
 * Assumes pull-ups on both lines: a released line reads 1.
 */
`timescale 1ns/100ps
`default_nettype none
module ifw_bus_master
(
    output var logic scl_drv,
    output var logic sda_drv
);
    // Lines idle released; SCL stands still between frames
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Start, 8 bits MSB first, released ack slot, stop; 80 ns bit time
    task automatic send(input logic [7:0] b);
        integer i;
        begin
            #3;
            sda_drv = 1'b0;
            #40;
            for (i = 0; i < 9; i = i + 1)
            begin
                scl_drv = 1'b0;
                #20;
                sda_drv = (i < 8) ? b[7 - i] : 1'b1;
                #20;
                scl_drv = 1'b1;
                #40;
            end
            scl_drv = 1'b0;
            #20;
            sda_drv = 1'b0;
            #20;
            scl_drv = 1'b1;
            #20;
            sda_drv = 1'b1;
            #40;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/test_ifw_top.sv ====
/*
 * Self-checking bench for ifw_top over its register port.
 * Assumes the bus master model drives SCL and SDA with pull-ups.
 */
`timescale 1ns/100ps
`default_nettype none
module test_ifw_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        master_mode = 1'b0;
    logic        si_flag = 1'b0;
    logic        power_down = 1'b0;
    logic [3:0]  strb = 4'h0;
    logic [7:0]  rx_data = 8'h00;
    logic [27:0] own_addr = 28'h000_0000;
    logic [27:0] adr_mask = 28'h000_0000;
    wire  [31:0] reg_rdata;
    wire  [7:0]  tx_data;
    wire         irq, start_issue, stop_issue, wake_req, dual_on;
    wire         scl_out, scl_oe, scl_drv, sda_drv;
    integer      n_errors = 0;
    integer      checks = 0;
    integer      n_start = 0, n_stop = 0, n_wake = 0;
    integer      i;

    always #5 clk = ~clk;
    // Count output pulses
    always @(posedge clk)
    begin
        n_start <= n_start + start_issue;
        n_stop <= n_stop + stop_issue;
        n_wake <= n_wake + wake_req;
    end

    ifw_top ifw_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .master_mode(master_mode), .si_flag(si_flag), .power_down(power_down),
        .core_tx_take(strb[0]), .core_tx_data(tx_data), .core_rx_push(strb[1]),
        .core_rx_data(rx_data), .start_request(strb[2]), .stop_request(strb[3]),
        .start_issue(start_issue), .stop_issue(stop_issue), .own_slave_address(own_addr),
        .slave_match_mask(adr_mask), .wake_req(wake_req), .dual_queue_on(dual_on),
        .scl_in(scl_drv & ~scl_oe), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_drv));
    ifw_bus_master ifw_bus_master_inst (.scl_drv(scl_drv), .sda_drv(sda_drv));

    // -----------------------------------------------------------------
    // Access tasks
    // -----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            @(negedge clk);
            chk($sformatf("reg %h", a), reg_rdata, exp);
        end
    endtask
    task automatic idle(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task automatic pulse(input integer k);
        begin
            @(posedge clk);
            strb[k] <= 1'b1;
            @(posedge clk);
            strb[k] <= 1'b0;
        end
    endtask
    task automatic wrap_up;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // Bound on the whole run
    initial
    begin
        #500000;
        n_errors = n_errors + 1;
        wrap_up;
    end

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(8'h3c, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        $display("test reset done");
        wr(8'h3c, 32'h0000_001a);
        idle(2);
        chk("dual_on", dual_on, 1'b1);
        rd(8'h40, 32'h0000_0004);
        wr(8'h4c, 32'h0000_00a5);
        wr(8'h4c, 32'h0000_005a);
        wr(8'h4c, 32'h0000_0077);
        rd(8'h40, 32'h0000_0006);
        chk("tx_data", tx_data, 8'ha5);
        pulse(0);
        idle(2);
        chk("tx_data", tx_data, 8'h5a);
        pulse(0);
        pulse(0);
        idle(2);
        chk("irq", irq, 1'b1);
        rd(8'h40, 32'h0000_0014);
        rd(8'h40, 32'h0000_0014);
        wr(8'h40, 32'h0000_0010);
        idle(2);
        chk("irq", irq, 1'b0);
        rd(8'h44, 32'h0000_0001);
        rd(8'h44, 32'h0000_0000);
        for (i = 0; i < 3; i = i + 1)
        begin
            rx_data <= rx_data + 8'h11;
            pulse(1);
        end
        idle(2);
        chk("irq", irq, 1'b1);
        rd(8'h40, 32'h0000_0008);
        rd(8'h50, 32'h0000_0011);
        rd(8'h50, 32'h0000_0022);
        rd(8'h40, 32'h0000_000c);
        wr(8'h3c, 32'h0000_0002);
        wr(8'h40, 32'h0000_0008);
        for (i = 0; i < 3; i = i + 1)
            pulse(1);
        idle(2);
        chk("irq", irq, 1'b0);
        wr(8'h48, 32'h0000_0002);
        idle(2);
        chk("irq", irq, 1'b1);
        rd(8'h44, 32'h0000_0002);
        idle(2);
        chk("irq", irq, 1'b0);
        $display("test queue done");
        wr(8'h3c, 32'h0000_0000);
        wr(8'h4c, 32'h0000_003c);
        wr(8'h4c, 32'h0000_00c3);
        idle(2);
        chk("dual_on", dual_on, 1'b0);
        chk("tx_data", tx_data, 8'h3c);
        rd(8'h40, 32'h0000_0008);
        pulse(0);
        pulse(0);
        wr(8'h40, 32'h0000_0008);
        rd(8'h40, 32'h0000_0000);
        $display("test single done");
        @(posedge clk);
        master_mode <= 1'b1;
        si_flag <= 1'b1;
        idle(3);
        chk("scl_oe", scl_oe, 1'b1);
        wr(8'h3c, 32'h0000_0004);
        idle(3);
        chk("scl_oe", scl_oe, 1'b0);
        wr(8'h3c, 32'h0000_0000);
        idle(3);
        chk("scl_oe", scl_oe, 1'b1);
        @(posedge clk);
        master_mode <= 1'b0;
        idle(3);
        chk("scl_oe", scl_oe, 1'b0);
        $display("test hold done");
        wr(8'h3c, 32'h0000_0002);
        pulse(2);
        idle(3);
        chk("starts", n_start, 0);
        @(posedge clk);
        si_flag <= 1'b0;
        pulse(2);
        idle(3);
        chk("starts", n_start, 1);
        wr(8'h4c, 32'h0000_0099);
        pulse(3);
        idle(4);
        chk("stops", n_stop, 0);
        pulse(0);
        idle(4);
        chk("stops", n_stop, 1);
        $display("test start stop done");
        own_addr <= 28'h00a_8000;
        adr_mask <= 28'h000_4000;
        wr(8'h3c, 32'h0000_0001);
        @(posedge clk);
        power_down <= 1'b1;
        ifw_bus_master_inst.send(8'h57);
        idle(6);
        chk("wakes", n_wake, 1);
        rd(8'h40, 32'h0000_0001);
        rd(8'h44, 32'h0000_0004);
        wr(8'h40, 32'h0000_0001);
        rd(8'h40, 32'h0000_0000);
        ifw_bus_master_inst.send(8'h51);
        idle(6);
        chk("wakes", n_wake, 1);
        @(posedge clk);
        power_down <= 1'b0;
        ifw_bus_master_inst.send(8'h55);
        idle(6);
        chk("wakes", n_wake, 1);
        $display("test wake done");
        wrap_up;
    end
endmodule
`default_nettype wire
